/* File: dv/aie_core_bench.sv */
// self-checking bench for the add/and instruction execute block
`timescale 1ns/1ps
module aie_core_bench;
	import aie_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic vld = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic ext = 1'b0;
	logic [3:0] bank_select_register = 4'h0;
	logic [11:0] base = 12'h123;
	logic [7:0] rdata = 8'h00;
	logic [1:0] phase;
	logic accept, mrd, mwr, done;
	logic [11:0] maddr;
	logic [7:0] wdata, acc;
	aie_flags_t status;
	int fails = 0;
	int num_checks = 0;
	logic [7:0] acc_m = 8'h00;
	aie_flags_t flg_m = 5'h00;
	// entry: [31] extended set, [27:24] bank, [23:16] memory byte, [15:0] word
	logic [31:0] tbl [19] = '{32'h0000_0f10, 32'h0000_0f15, 32'h0000_0ff0, 32'h0000_0b0a,
		32'h0040_2133, 32'h05c2_2733, 32'h0001_2420, 32'h0001_2480, 32'h8007_245f,
		32'h8007_2460, 32'h00ff_2310, 32'h0000_0b00, 32'h0000_0f7f, 32'h0000_0f01,
		32'h0000_ffff, 32'h0000_0f22, 32'h0000_0b5f, 32'h0000_0fff, 32'h0010_2310};

	always #5 clk = ~clk;

	aie_core dut (
		.I_CLK_SYS(clk),
		.I_RESET(rst),
		.I_INSTR_VALID(vld),
		.I_INSTR(instr),
		.I_EXT_SET_EN(ext),
		.I_BANK_SELECT_REGISTER(bank_select_register),
		.I_INDEX_BASE(base),
		.I_MEM_RDATA(rdata),
		.O_PHASE(phase),
		.O_INSTR_ACCEPT(accept),
		.O_MEM_ADDR(maddr),
		.O_MEM_RD(mrd),
		.O_MEM_WR(mwr),
		.O_MEM_WDATA(wdata),
		.O_ACCUMULATOR(acc),
		.O_STATUS(status),
		.O_DONE(done)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic exec(input logic [31:0] e);
		logic [15:0] w;
		logic [7:0] f, b, r;
		logic [8:0] s;
		logic [11:0] ea;
		logic cin, file, known, dst;
		aie_flags_t nf;
		int n;
		w = e[15:0];
		f = w[7:0];
		n = 0;
		// wait for the fourth phase, sampled off the edge, so the word stands through the next first phase
		while (phase !== 2'd3)
		begin
			n++;
			if (n > 8)
			begin
				fails++;
				tally_and_finish();
			end
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		ext <= e[31];
		bank_select_register <= e[27:24];
		rdata <= e[23:16];
		instr <= w;
		vld <= 1'b1;
		file = (w[15:10] == OPC_ADD_FILE) || (w[15:10] == OPC_ADD_FILE_C);
		known = file || (w[15:8] == OPC_ADD_LIT) || (w[15:8] == OPC_AND_LIT);
		dst = file && w[9];
		b = file ? e[23:16] : f;
		cin = (w[15:10] == OPC_ADD_FILE_C) && flg_m.c;
		s = {1'b0, acc_m} + {1'b0, b} + {8'h00, cin};
		nf.c = s[8];
		nf.nibble_carry_flag = ({1'b0, acc_m[3:0]} + {1'b0, b[3:0]} + {4'h0, cin}) > 5'h0f;
		nf.signed_overflow_flag = (acc_m[7] == b[7]) && (s[7] != acc_m[7]);
		r = s[7:0];
		if (w[15:8] == OPC_AND_LIT)
		begin
			r = acc_m & f;
			nf = flg_m;
		end
		nf.n = r[7];
		nf.z = (r == 8'h00);
		if (w[8])
			ea = {e[27:24], f};
		else if (e[31] && f <= 8'h5f)
			ea = base + {4'h0, f};
		else
			ea = {(f < 8'h60) ? 4'h0 : 4'hf, f};
		@(posedge clk);
		#1;
		check(16'(accept), 16'h0001, "accept");
		check(16'(mrd), 16'(file), "read strobe");
		if (file)
			check(16'(maddr), 16'(ea), "address");
		@(posedge clk);
		vld <= 1'b0;
		rdata <= ~e[23:16];
		#1;
		check(16'(accept), 16'h0000, "late valid taken");
		@(posedge clk);
		#1;
		check(16'(done), 16'(known), "done");
		check(16'(mwr), 16'(dst), "write strobe");
		if (known)
		begin
			flg_m = nf;
			if (!dst)
				acc_m = r;
		end
		if (dst)
			check(16'(wdata), 16'(r), "write data");
		check(16'(acc), 16'(acc_m), "accumulator");
		check(16'(status), 16'(flg_m), "status");
	endtask

	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		#1;
		check(16'(phase), 16'h0000, "reset phase");
		check(16'(acc), 16'(ACC_RST), "reset accumulator");
		check(16'(status), 16'(FLAGS_RST), "reset status");
		$display("reset test done");
		for (int i = 0; i < 19; i++)
		begin
			exec(tbl[i]);
			$display("instruction test %0d done", i);
		end
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		check(16'(phase), 16'h0000, "mid-run reset phase");
		check(16'(acc), 16'(ACC_RST), "mid-run reset accumulator");
		check(16'(status), 16'(FLAGS_RST), "mid-run reset status");
		acc_m = ACC_RST;
		flg_m = FLAGS_RST;
		exec(32'h0000_0f80);
		$display("mid-run reset test done");
		tally_and_finish();
	end
endmodule

/* File: hdl/aie_adder.sv */
// eight-bit adder with carry, nibble carry and signed overflow
`timescale 1ns/1ps
module aie_adder #(
	parameter int W = 8
) (
	input wire logic [W-1:0] i_a,
	input wire logic [W-1:0] i_b,
	input wire logic i_cin,
	output logic [W-1:0] o_sum,
	output logic o_cout,
	output logic o_nib_carry,
	output logic o_ovf
);
	logic [W:0] full;
	logic [4:0] low;

	always_comb
	begin
		full = {1'b0, i_a} + {1'b0, i_b} + {{W{1'b0}}, i_cin};
		low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
		o_sum = full[W-1:0];
		o_cout = full[W];
		o_nib_carry = low[4];
		// overflow when both operands share a sign the sum does not
		o_ovf = (i_a[W-1] == i_b[W-1]) && (full[W-1] != i_a[W-1]);
	end
endmodule

/* File: hdl/aie_core.sv */
// execute stage for add-literal, and-literal, add-to-file and add-with-carry
// Contract
// - add-accumulator-to-file (0010 01da ffff ffff) sums accumulator and the addressed byte.
// - with destination bit 0 the result goes to the accumulator and memory is untouched.
// - with destination bit 1 the result is written back to the addressed byte instead.
// - with bank bit 0 the file address resolves in the fixed access bank.
// - with bank bit 1 the bank select register chooses the register bank.
// - with bank bit 0 and extended set on, addresses up to 95 use indexed literal offset.
// - add-with-carry (0010 00da) sums accumulator, addressed byte and carry to the destination.
// - add instructions update negative, overflow, carry, nibble carry and zero from the result.
// - and-literal (0000 1011 kkkk kkkk) ands the accumulator with the literal into it.
// - and-literal updates only negative and zero.
// - add-with-carry with destination bit 1 places the result in the addressed byte.
// - add-literal (0000 1111 kkkk kkkk) adds the literal into the accumulator.
`timescale 1ns/1ps
module aie_core (
	input wire logic I_CLK_SYS,
	input wire logic I_RESET,
	input wire logic I_INSTR_VALID,
	input wire logic [aie_pkg::INSTR_W-1:0] I_INSTR,
	input wire logic I_EXT_SET_EN,
	input wire logic [aie_pkg::BANK_W-1:0] I_BANK_SELECT_REGISTER,
	input wire logic [aie_pkg::ADDR_W-1:0] I_INDEX_BASE,
	input wire logic [aie_pkg::DATA_W-1:0] I_MEM_RDATA,
	output logic [1:0] O_PHASE,
	output logic O_INSTR_ACCEPT,
	output logic [aie_pkg::ADDR_W-1:0] O_MEM_ADDR,
	output logic O_MEM_RD,
	output logic O_MEM_WR,
	output logic [aie_pkg::DATA_W-1:0] O_MEM_WDATA,
	output logic [aie_pkg::DATA_W-1:0] O_ACCUMULATOR,
	output aie_pkg::aie_flags_t O_STATUS,
	output logic O_DONE
);
	import aie_pkg::*;

	aie_phase_t ph_q, ph_d;
	aie_dec_t dec_q, dec_d;
	aie_dec_t dec_now;
	logic accept_q, accept_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [ADDR_W-1:0] addr_now;
	logic rd_q, rd_d;
	logic wr_q, wr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic [DATA_W-1:0] opnd_q, opnd_d;
	logic [DATA_W-1:0] acc_q, acc_d;
	aie_flags_t sts_q, sts_d;
	logic done_q, done_d;
	logic [DATA_W-1:0] sum;
	logic cout, nib, ovf, cin;
	logic [DATA_W-1:0] result;
	logic file_op;
	logic [7:0] f;

	aie_adder #(
		.W(DATA_W)
	) u_adder (
		.i_a(acc_q),
		.i_b(opnd_q),
		.i_cin(cin),
		.o_sum(sum),
		.o_cout(cout),
		.o_nib_carry(nib),
		.o_ovf(ovf)
	);

	// decode and address resolution of the word on I_INSTR
	always_comb
	begin
		dec_now = DEC_RST;
		f = I_INSTR[LIT_LSB +: 8];
		dec_now.field = f;
		dec_now.dest_file = I_INSTR[DEST_BIT];
		if (I_INSTR[15:8] == OPC_ADD_LIT)
		begin
			dec_now.op = OP_ADD_LIT;
		end
		else if (I_INSTR[15:8] == OPC_AND_LIT)
		begin
			dec_now.op = OP_AND_LIT;
		end
		else if (I_INSTR[15:10] == OPC_ADD_FILE)
		begin
			dec_now.op = OP_ADD_FILE;
		end
		else if (I_INSTR[15:10] == OPC_ADD_FILE_C)
		begin
			dec_now.op = OP_ADD_FILE_C;
		end
		if (I_INSTR[BANK_BIT])
		begin
			addr_now = {I_BANK_SELECT_REGISTER, f};
		end
		else if (I_EXT_SET_EN && f <= INDEXED_MAX)
		begin
			addr_now = I_INDEX_BASE + {4'h0, f};
		end
		else if (f < ACCESS_SPLIT)
		begin
			addr_now = {ACCESS_LOW_PAGE, f};
		end
		else
		begin
			addr_now = {ACCESS_HIGH_PAGE, f};
		end
	end

	always_comb
	begin
		file_op = (dec_q.op == OP_ADD_FILE) || (dec_q.op == OP_ADD_FILE_C);
		cin = (dec_q.op == OP_ADD_FILE_C) ? sts_q.c : 1'b0;
		result = (dec_q.op == OP_AND_LIT) ? (acc_q & opnd_q) : sum;
		ph_d = ph_q;
		dec_d = dec_q;
		accept_d = 1'b0;
		addr_d = addr_q;
		rd_d = 1'b0;
		wr_d = 1'b0;
		wdata_d = wdata_q;
		opnd_d = opnd_q;
		acc_d = acc_q;
		sts_d = sts_q;
		done_d = 1'b0;
		unique case (ph_q)
			PH_Q1:
			begin
				// decode; an instruction is only taken here
				ph_d = PH_Q2;
				dec_d = DEC_RST;
				if (I_INSTR_VALID)
				begin
					dec_d = dec_now;
					accept_d = 1'b1;
					addr_d = addr_now;
					rd_d = (dec_now.op == OP_ADD_FILE) || (dec_now.op == OP_ADD_FILE_C);
				end
			end
			PH_Q2:
			begin
				// read operand: memory byte or the literal field
				ph_d = PH_Q3;
				opnd_d = file_op ? I_MEM_RDATA : dec_q.field;
			end
			PH_Q3:
			begin
				// compute and register the destination for the write phase
				ph_d = PH_Q4;
				done_d = dec_q.op != OP_NONE;
				if (dec_q.op != OP_NONE)
				begin
					sts_d.n = result[DATA_W-1];
					sts_d.z = result == DATA_RST;
				end
				if (dec_q.op != OP_NONE && dec_q.op != OP_AND_LIT)
				begin
					sts_d.c = cout;
					sts_d.nibble_carry_flag = nib;
					sts_d.signed_overflow_flag = ovf;
				end
				if (file_op && dec_q.dest_file)
				begin
					wr_d = 1'b1;
					wdata_d = result;
				end
				else if (dec_q.op != OP_NONE)
				begin
					acc_d = result;
				end
			end
			PH_Q4:
			begin
				ph_d = PH_Q1;
			end
		endcase
	end

	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_RESET)
		begin
			ph_q <= PH_Q1;
			dec_q <= DEC_RST;
			accept_q <= 1'b0;
			addr_q <= ADDR_RST;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			wdata_q <= DATA_RST;
			opnd_q <= DATA_RST;
			acc_q <= ACC_RST;
			sts_q <= FLAGS_RST;
			done_q <= 1'b0;
		end
		else
		begin
			ph_q <= ph_d;
			dec_q <= dec_d;
			accept_q <= accept_d;
			addr_q <= addr_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			wdata_q <= wdata_d;
			opnd_q <= opnd_d;
			acc_q <= acc_d;
			sts_q <= sts_d;
			done_q <= done_d;
		end
	end

	always_comb
	begin
		O_PHASE = ph_q;
		O_INSTR_ACCEPT = accept_q;
		O_MEM_ADDR = addr_q;
		O_MEM_RD = rd_q;
		O_MEM_WR = wr_q;
		O_MEM_WDATA = wdata_q;
		O_ACCUMULATOR = acc_q;
		O_STATUS = sts_q;
		O_DONE = done_q;
	end

	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_RESET);

	logic in_q1;
	assign in_q1 = ph_q == PH_Q1;

	chk_phase_walk: assert property (in_q1 |=> ph_q == PH_Q2 ##1 ph_q == PH_Q3 ##1 ph_q == PH_Q4)
		else $error("phase sequence broken");

	chk_one_cycle: assert property (in_q1 && I_INSTR_VALID && dec_now.op != OP_NONE |-> ##3 done_q ##1 in_q1)
		else $error("instruction did not finish within its cycle");

	chk_add_lit_sum: assert property (ph_q == PH_Q3 && dec_q.op == OP_ADD_LIT
		|=> acc_q == DATA_W'($past(acc_q) + $past(opnd_q)))
		else $error("add literal sum wrong");

	chk_and_lit_val: assert property (ph_q == PH_Q3 && dec_q.op == OP_AND_LIT
		|=> acc_q == ($past(acc_q) & $past(opnd_q)))
		else $error("and literal result wrong");

	chk_and_keeps_flags: assert property (ph_q == PH_Q3 && dec_q.op == OP_AND_LIT
		|=> $stable(sts_q.c) && $stable(sts_q.nibble_carry_flag) && $stable(sts_q.signed_overflow_flag))
		else $error("and literal touched arithmetic flags");

	chk_file_sum: assert property (ph_q == PH_Q3 && dec_q.op == OP_ADD_FILE && dec_q.dest_file
		|=> wr_q && wdata_q == DATA_W'($past(acc_q) + $past(opnd_q)))
		else $error("add to file sum wrong");

	chk_dest_acc: assert property (ph_q == PH_Q3 && file_op && !dec_q.dest_file
		|=> !wr_q && acc_q == DATA_W'($past(acc_q) + $past(opnd_q) + {7'h00, $past(dec_q.op == OP_ADD_FILE_C && sts_q.c)}))
		else $error("accumulator destination wrong");

	chk_dest_file: assert property (ph_q == PH_Q3 && file_op && dec_q.dest_file
		|=> wr_q && $stable(acc_q) ##1 !wr_q)
		else $error("file destination wrong");

	chk_carry_sum: assert property (ph_q == PH_Q3 && dec_q.op == OP_ADD_FILE_C && dec_q.dest_file
		|=> wdata_q == DATA_W'($past(acc_q) + $past(opnd_q) + {7'h00, $past(sts_q.c)}))
		else $error("add with carry result wrong");

	chk_zero_flag: assert property (ph_q == PH_Q3 && dec_q.op != OP_NONE
		|=> sts_q.z == ($past(result) == DATA_RST) && sts_q.n == $past(result[DATA_W-1]))
		else $error("zero or negative flag wrong");

	chk_add_carry_out: assert property (ph_q == PH_Q3 && dec_q.op == OP_ADD_LIT
		|=> {sts_q.c, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(opnd_q)})
		else $error("add literal carry wrong");

	chk_nop_idle: assert property (ph_q == PH_Q3 && dec_q.op == OP_NONE
		|=> !done_q && !wr_q && $stable(acc_q) && $stable(sts_q))
		else $error("unrecognised word changed state");

	chk_read_phase: assert property (rd_q |-> ph_q == PH_Q2)
		else $error("operand read outside second phase");

	chk_write_phase: assert property (wr_q |-> ph_q == PH_Q4)
		else $error("destination write outside fourth phase");

	chk_bank_addr: assert property (in_q1 && I_INSTR_VALID && I_INSTR[BANK_BIT]
		|=> addr_q == {$past(I_BANK_SELECT_REGISTER), $past(I_INSTR[7:0])})
		else $error("banked address wrong");

	chk_access_addr: assert property (in_q1 && I_INSTR_VALID && !I_INSTR[BANK_BIT] && !I_EXT_SET_EN
		|=> addr_q[7:0] == $past(I_INSTR[7:0])
		&& addr_q[11:8] == (($past(I_INSTR[7:0]) < ACCESS_SPLIT) ? ACCESS_LOW_PAGE : ACCESS_HIGH_PAGE))
		else $error("access bank address wrong");

	chk_indexed_addr: assert property (in_q1 && I_INSTR_VALID && !I_INSTR[BANK_BIT] && I_EXT_SET_EN
		&& I_INSTR[7:0] <= INDEXED_MAX |=> addr_q == $past(I_INDEX_BASE) + {4'h0, $past(I_INSTR[7:0])})
		else $error("indexed address wrong");

	cov_add_carry_file: cover property (ph_q == PH_Q3 && dec_q.op == OP_ADD_FILE_C && sts_q.c && dec_q.dest_file);
	cov_indexed: cover property (in_q1 && I_INSTR_VALID && !I_INSTR[BANK_BIT] && I_EXT_SET_EN);
	cov_overflow: cover property (ph_q == PH_Q3 && dec_q.op == OP_ADD_LIT && ovf);
	cov_and_zero: cover property (ph_q == PH_Q3 && dec_q.op == OP_AND_LIT && result == DATA_RST);
	cov_access_high: cover property (in_q1 && I_INSTR_VALID && !I_INSTR[BANK_BIT] && I_INSTR[7:0] >= ACCESS_SPLIT);

endmodule

/* File: hdl/aie_pkg.sv */
// constants and types for the add/and instruction execute block
package aie_pkg;

	localparam int INSTR_W = 16;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;
	localparam int BANK_W = 4;

	// opcode fields, upper instruction bits
	localparam logic [7:0] OPC_ADD_LIT = 8'h0f;
	localparam logic [7:0] OPC_AND_LIT = 8'h0b;
	localparam logic [5:0] OPC_ADD_FILE = 6'h09;
	localparam logic [5:0] OPC_ADD_FILE_C = 6'h08;

	// field positions
	localparam int DEST_BIT = 9;
	localparam int BANK_BIT = 8;
	localparam int LIT_LSB = 0;

	// address resolution
	localparam logic [7:0] INDEXED_MAX = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hf;

	// reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [11:0] ADDR_RST = 12'h000;
	localparam logic [7:0] DATA_RST = 8'h00;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_ADD_LIT,
		OP_AND_LIT,
		OP_ADD_FILE,
		OP_ADD_FILE_C
	} aie_op_t;

	typedef enum logic [1:0] {
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} aie_phase_t;

	typedef struct packed {
		logic n;
		logic signed_overflow_flag;
		logic z;
		logic nibble_carry_flag;
		logic c;
	} aie_flags_t;

	localparam aie_flags_t FLAGS_RST = 5'h00;

	typedef struct packed {
		aie_op_t op;
		logic dest_file;
		logic [7:0] field;
	} aie_dec_t;

	localparam aie_dec_t DEC_RST = '{op: OP_NONE, dest_file: 1'b0, field: 8'h00};

endpackage
